/* hw/srg_regs.vh */
`ifndef SRG_REGS_VH
`define SRG_REGS_VH

// ------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ------------------------------------------------------------
`define SRG_OFS_CTRL 8'h00
`define SRG_OFS_INIT 8'h04
`define SRG_OFS_TARGET 8'h08
`define SRG_OFS_LENGTH 8'h0C
`define SRG_OFS_CURRENT 8'h10
`define SRG_OFS_SCANCNT 8'h14
`define SRG_OFS_PERIOD 8'h18
`define SRG_OFS_IRQ_STAT 8'h1C
`define SRG_OFS_IRQ_MASK 8'h20
`define SRG_OFS_FLAGS 8'h24

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SRG_CTRL_CSCAN_BIT 0
`define SRG_CTRL_MODE_BIT 1
`define SRG_IRQ_DONE_BIT 0
`define SRG_IRQ_PAUSE_BIT 1
`define SRG_FLAG_DONE_BIT 0
`define SRG_FLAG_BUSY_BIT 1
`define SRG_FLAG_PAUSED_BIT 2

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define SRG_RST_WORD 16'h0000
`define SRG_RST_LENGTH 16'h0001
`define SRG_RST_IRQ 2'h0
`define SRG_RST_PERIOD 16'h0000

`endif

/* hw/srg_scan_ramp.v */
`include "srg_regs.vh"

// Behaviour
// [RULE_01] each scan with command on adds one step
// [RULE_02] initial, target, current held as 16-bit words
// [RULE_03] software keeps length n within 1 to 32767
// [RULE_04] scan count word follows current word
// [RULE_05] ramp reaches target in exactly n scans
// [RULE_06] command off: hold value, clear scan count
// [RULE_07] command back on: restart from initial value
// [RULE_08] at target set done, then return initial
// [RULE_09] constant-scan mode stretches each scan to period
// [RULE_10] mode flag cleared on leaving run mode
// [RULE_11] software clears retained current before run
// [RULE_12] signed steps, truncated, final step exact
module srg_scan_ramp (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire cmd_on,
  input wire run_mode,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  output reg [31:0] rdata,
  output wire irq,
  output wire instruction_done_flag,
  output wire [15:0] ramp_current
);

  // ----------------------------------------------------------
  // states
  // ----------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_RUN = 4'h2;
  localparam [3:0] ST_PAUSE = 4'h4;
  localparam [3:0] ST_DONE = 4'h8;

  // ----------------------------------------------------------
  // storage
  // ----------------------------------------------------------
  reg [15:0] ramp_initial_value_reg;
  reg [15:0] ramp_target_value_reg;
  reg [15:0] length_reg;
  reg [15:0] current_reg;
  reg [15:0] current_next;
  reg [15:0] scan_count_reg;
  reg [15:0] scan_count_next;
  reg [15:0] constant_scan_period_word_reg;
  reg constant_scan_enable_reg;
  reg ramp_mode_flag_reg;
  reg done_reg;
  reg done_next;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [15:0] tick_cnt_reg;
  reg run_mode_d_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_mask_reg;
  reg ev_done;
  reg ev_pause;
  wire scan_tick;
  wire [16:0] step_count;
  wire signed [16:0] span;
  wire signed [33:0] scaled;
  wire signed [33:0] offset;
  wire signed [16:0] ramp_point;
  wire [1:0] ev_vec;

  // ----------------------------------------------------------
  // operation cycle timing
  // ----------------------------------------------------------
  // a period word of zero or one means a scan every cycle, so a
  // careless write cannot stop the ramp
  assign scan_tick = ~constant_scan_enable_reg |
    (tick_cnt_reg + 16'h0001 >= constant_scan_period_word_reg); // see [RULE_09]

  // scan period counter, restarts every scan
  always @(posedge clk)
  begin
    if (!rst_n)
      tick_cnt_reg <= 16'h0000;
    else if (ce)
    begin
      if (scan_tick)
        tick_cnt_reg <= 16'h0000;
      else
        tick_cnt_reg <= tick_cnt_reg + 16'h0001; // see [RULE_09]
    end
  end

  // ----------------------------------------------------------
  // ramp arithmetic
  // ----------------------------------------------------------
  // value at step k = initial + (target - initial) * k / n; the
  // division truncates toward zero, and at k = n it is exact, so
  // rounding never accumulates and the last point is the target
  assign step_count = {1'b0, scan_count_reg} + 17'h00001;
  assign span = $signed({ramp_target_value_reg[15],
    ramp_target_value_reg}) - $signed({ramp_initial_value_reg[15],
    ramp_initial_value_reg}); // see [RULE_12]
  assign scaled = span * $signed({1'b0, step_count});
  // a length of zero is refused as one to keep the divide defined
  assign offset = (length_reg == 16'h0000) ? scaled :
    scaled / $signed({18'h00000, length_reg}); // see [RULE_03]
  assign ramp_point = $signed({ramp_initial_value_reg[15],
    ramp_initial_value_reg}) + offset[16:0]; // see [RULE_12]

  // ----------------------------------------------------------
  // ramp sequencer
  // ----------------------------------------------------------
  // the sequencer only moves on a scan while the controller runs
  always @*
  begin
    state_next = state_reg;
    current_next = current_reg;
    scan_count_next = scan_count_reg;
    done_next = done_reg;
    ev_done = 1'b0;
    ev_pause = 1'b0;
    if (scan_tick && run_mode)
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (cmd_on)
          begin
            current_next = ramp_initial_value_reg;
            scan_count_next = 16'h0000;
            done_next = 1'b0;
            state_next = ST_RUN;
          end
        end
        ST_RUN:
        begin
          if (!cmd_on)
          begin
            scan_count_next = 16'h0000; // see [RULE_06]
            state_next = ST_PAUSE; // see [RULE_06]
            ev_pause = 1'b1;
          end
          else
          begin
            current_next = ramp_point[15:0]; // see [RULE_01]
            scan_count_next = step_count[15:0]; // see [RULE_04]
            if (step_count[15:0] >= length_reg)
            begin
              current_next = ramp_target_value_reg; // see [RULE_05]
              done_next = 1'b1; // see [RULE_08]
              ev_done = 1'b1;
              state_next = ST_DONE;
            end
          end
        end
        ST_PAUSE:
        begin
          if (cmd_on)
          begin
            // restart clears the held value and loads the start
            current_next = ramp_initial_value_reg; // see [RULE_07]
            scan_count_next = 16'h0000;
            done_next = 1'b0;
            state_next = ST_RUN; // see [RULE_07]
          end
        end
        ST_DONE:
        begin
          // the finished ramp falls back to the start value
          current_next = ramp_initial_value_reg; // see [RULE_08]
          scan_count_next = 16'h0000;
          done_next = 1'b0;
          state_next = cmd_on ? ST_RUN : ST_IDLE;
        end
        default:
        begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // sequencer state; the current word survives a stop of the
  // controller, which is why software must clear it before run
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      current_reg <= `SRG_RST_WORD;
      scan_count_reg <= `SRG_RST_WORD;
      done_reg <= 1'b0;
    end
    else if (ce)
    begin
      if (wr && addr == `SRG_OFS_CURRENT)
        current_reg <= wdata[15:0]; // see [RULE_11]
      else
        current_reg <= current_next;
      state_reg <= state_next;
      scan_count_reg <= scan_count_next;
      done_reg <= done_next;
    end
  end

  // ----------------------------------------------------------
  // software registers
  // ----------------------------------------------------------
  // configuration words; the ramp reads them live, so changing
  // them mid-ramp bends the curve
  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      ramp_initial_value_reg <= `SRG_RST_WORD;
      ramp_target_value_reg <= `SRG_RST_WORD;
      length_reg <= `SRG_RST_LENGTH;
      constant_scan_period_word_reg <= `SRG_RST_PERIOD;
      constant_scan_enable_reg <= 1'b0;
      ramp_mode_flag_reg <= 1'b0;
      irq_mask_reg <= `SRG_RST_IRQ;
      run_mode_d_reg <= 1'b0;
    end
    else if (ce)
    begin
      run_mode_d_reg <= run_mode;
      if (wr)
      begin
        case (addr)
          `SRG_OFS_CTRL:
          begin
            constant_scan_enable_reg <=
              wdata[`SRG_CTRL_CSCAN_BIT]; // see [RULE_09]
            ramp_mode_flag_reg <= wdata[`SRG_CTRL_MODE_BIT];
          end
          `SRG_OFS_INIT:
            ramp_initial_value_reg <= wdata[15:0]; // see [RULE_02]
          `SRG_OFS_TARGET:
            ramp_target_value_reg <= wdata[15:0]; // see [RULE_02]
          `SRG_OFS_LENGTH:
            length_reg <= wdata[15:0];
          `SRG_OFS_PERIOD:
            constant_scan_period_word_reg <= wdata[15:0];
          `SRG_OFS_IRQ_MASK:
            irq_mask_reg <= wdata[1:0];
          default:
          begin
          end
        endcase
      end
      // leaving run mode wins over a write in the same cycle
      if (run_mode_d_reg && !run_mode)
        ramp_mode_flag_reg <= 1'b0; // see [RULE_10]
    end
  end

  // ----------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------
  assign ev_vec = {ev_pause, ev_done};

  // sticky status, write one to clear; a new event beats the clear
  always @(posedge clk)
  begin
    if (!rst_n)
      irq_stat_reg <= `SRG_RST_IRQ;
    else if (ce)
    begin
      if (wr && addr == `SRG_OFS_IRQ_STAT)
        irq_stat_reg <= (irq_stat_reg & ~wdata[1:0]) | ev_vec;
      else
        irq_stat_reg <= irq_stat_reg | ev_vec;
    end
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------
  // read port
  // ----------------------------------------------------------
  // read data stand only in the cycle after the strobe
  always @(posedge clk)
  begin
    if (!rst_n)
      rdata <= 32'h00000000;
    else if (ce)
    begin
      rdata <= 32'h00000000;
      if (rd)
      begin
        case (addr)
          `SRG_OFS_CTRL:
            rdata <= {30'h00000000, ramp_mode_flag_reg,
              constant_scan_enable_reg};
          `SRG_OFS_INIT:
            rdata <= {16'h0000, ramp_initial_value_reg};
          `SRG_OFS_TARGET:
            rdata <= {16'h0000, ramp_target_value_reg};
          `SRG_OFS_LENGTH:
            rdata <= {16'h0000, length_reg};
          `SRG_OFS_CURRENT:
            rdata <= {16'h0000, current_reg};
          `SRG_OFS_SCANCNT:
            rdata <= {16'h0000, scan_count_reg}; // see [RULE_04]
          `SRG_OFS_PERIOD:
            rdata <= {16'h0000, constant_scan_period_word_reg};
          `SRG_OFS_IRQ_STAT:
            rdata <= {30'h00000000, irq_stat_reg};
          `SRG_OFS_IRQ_MASK:
            rdata <= {30'h00000000, irq_mask_reg};
          `SRG_OFS_FLAGS:
            rdata <= {29'h00000000, state_reg == ST_PAUSE,
              state_reg == ST_RUN, done_reg};
          default:
            rdata <= 32'h00000000;
        endcase
      end
    end
  end

  assign instruction_done_flag = done_reg; // see [RULE_08]
  assign ramp_current = current_reg;

endmodule // srg_scan_ramp

/* bench/srg_checker.sv */
`include "srg_regs.vh"

// ----------------------------------------
// port-level checks of the ramp block
// ----------------------------------------
module srg_checker (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire cmd_on,
  input wire run_mode,
  input wire [7:0] addr,
  input wire [31:0] wdata,
  input wire wr,
  input wire rd,
  input wire [31:0] rdata,
  input wire irq,
  input wire instruction_done_flag,
  input wire [15:0] ramp_current
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // a software write to the current word may move it at any time
  wire cur_wr = wr && addr == `SRG_OFS_CURRENT;
  sequence s_rd_cur;
    ce && rd && addr == `SRG_OFS_CURRENT;
  endsequence
  sequence s_quiet;
    ce && !cur_wr;
  endsequence
  property p_rd_cur;
    s_rd_cur |=> rdata == {16'h0000, $past(ramp_current)};
  endproperty
  a_rd_cur: assert property (p_rd_cur)
    else $error("current word read back wrong");
  property p_rd_idle;
    ce && !rd |=> rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not cleared");
  property p_rd_hi;
    $past(rd) |-> rdata[31:16] == 16'h0000;
  endproperty
  a_rd_hi: assert property (p_rd_hi)
    else $error("upper read bits set");
  property p_ce_hold;
    !ce |=> $stable(rdata) && $stable(ramp_current)
      && $stable(instruction_done_flag);
  endproperty
  a_ce_hold: assert property (p_ce_hold)
    else $error("outputs moved with enable low");
  property p_off_hold;
    s_quiet and !cmd_on && !instruction_done_flag |=> $stable(ramp_current);
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("value moved with command off");
  property p_stop_hold;
    s_quiet and !run_mode |=> $stable(ramp_current);
  endproperty
  a_stop_hold: assert property (p_stop_hold)
    else $error("value moved in stop mode");
  property p_done_cause;
    $rose(instruction_done_flag) |-> $past(cmd_on && run_mode && ce);
  endproperty
  a_done_cause: assert property (p_done_cause)
    else $error("done without a stepping scan");
  property p_done_fall;
    $fell(instruction_done_flag) |-> $past(ce) && $past(run_mode);
  endproperty
  a_done_fall: assert property (p_done_fall)
    else $error("done dropped off a scan");
endmodule // srg_checker

bind srg_scan_ramp srg_checker u_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
  .cmd_on(cmd_on), .run_mode(run_mode), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
  .instruction_done_flag(instruction_done_flag),
  .ramp_current(ramp_current));

/* bench/srg_scan_ramp_tb_top.sv */
`include "srg_regs.vh"

module srg_scan_ramp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, ce = 1, cmd_on = 0, run_mode = 1;
  logic wr = 0, rd = 0, irq, done;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [15:0] cur;
  int fails = 0, n_compared = 0, seed = 32'hcba8, n, p, c;
  srg_scan_ramp u_dut (.clk(clk), .rst_n(rst_n), .ce(ce), .cmd_on(cmd_on),
    .run_mode(run_mode), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq), .instruction_done_flag(done),
    .ramp_current(cur));
  // 4 ns period
  initial
    forever #2 clk = ~clk;
  // ----------------------------------------
  // compares and bus cycles
  // ----------------------------------------
  task chk(input logic [31:0] g, e);
    n_compared++;
    if (g !== e)
    begin
      fails++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chkv(input logic [15:0] g, e);
    chk({16'h0, g}, {16'h0, e});
  endtask
  task chkf(input logic g, e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  // signed step, truncated toward zero, so the last step is exact
  function logic [15:0] exp_cur(input logic [15:0] i, t, input int n, k);
    return 16'($signed(i) + ($signed(t) - $signed(i)) * k / n);
  endfunction
  // one ramp, optionally paused after step p and restarted
  task ramp(input logic [15:0] i, t, input int n, p);
    wreg(`SRG_OFS_INIT, {16'h0, i});
    wreg(`SRG_OFS_TARGET, {16'h0, t});
    wreg(`SRG_OFS_LENGTH, 32'(n));
    if (p > 0)
    begin
      @(posedge clk);
      cmd_on <= 1;
      repeat (p + 1) @(posedge clk);
      cmd_on <= 0;
      @(posedge clk);
      #1 chkv(cur, exp_cur(i, t, n, p));
      rchk(`SRG_OFS_SCANCNT, 32'h0);
      rchk(`SRG_OFS_FLAGS, 32'h4);
    end
    @(posedge clk);
    cmd_on <= 1;
    for (int k = 0; k <= n; k++)
    begin
      @(posedge clk);
      if (k == n)
      begin
        cmd_on <= 0;
        addr <= `SRG_OFS_SCANCNT;
        rd <= 1;
      end
      #1 chkv(cur, exp_cur(i, t, n, k));
    end
    chkf(done, 1);
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, 32'(n));
    chkv(cur, i);
    rchk(`SRG_OFS_IRQ_STAT, p > 0 ? 32'h3 : 32'h1);
    chkf(irq, 1);
    wreg(`SRG_OFS_IRQ_STAT, 32'h1);
    #1 chkf(irq, 0);
    wreg(`SRG_OFS_IRQ_STAT, 32'h2);
  endtask
  task final_report;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1;
    // 0x28 is past the map and must read 0
    for (int a = 0; a < 11; a++)
      rchk(8'(a * 4), a == 3 ? 32'h1 : 32'h0);
    chkf(irq, 0);
    rv = $random(seed);
    wreg(`SRG_OFS_CURRENT, rv);
    rchk(`SRG_OFS_CURRENT, {16'h0, rv[15:0]});
    wreg(`SRG_OFS_CURRENT, 32'h0);
    $display("test reset done");
    wreg(`SRG_OFS_IRQ_MASK, 32'h1);
    ramp(16'h0000, 16'h000A, 2, 0);
    ramp(16'h0064, 16'hFF9C, 7, 3);
    ramp(16'h7FFF, 16'h8000, 3, 1);
    ramp(16'h8000, 16'h7FFF, 1, 0);
    repeat (6)
    begin
      n = 1 + {$random(seed)} % 8;
      p = {$random(seed)} % n;
      ramp($random(seed), $random(seed), n, p);
    end
    $display("test ramps done");
    // done must stand one whole scan of 4 clocks
    wreg(`SRG_OFS_PERIOD, 32'h4);
    wreg(`SRG_OFS_CTRL, 32'h1);
    @(posedge clk);
    cmd_on <= 1;
    for (c = 0; done !== 1 && c < 200; c++)
      @(posedge clk) #1;
    for (c = 0; done === 1 && c < 200; c++)
      @(posedge clk) #1;
    chk(c, 32'h4);
    // leaving run mode while the enable is low still clears the mode flag
    @(posedge clk);
    cmd_on <= 0;
    wreg(`SRG_OFS_CTRL, 32'h2);
    wreg(`SRG_OFS_IRQ_STAT, 32'h3);
    rchk(`SRG_OFS_CTRL, 32'h2);
    @(posedge clk);
    run_mode <= 0;
    cmd_on <= 1;
    ce <= 0;
    repeat (3) @(posedge clk);
    ce <= 1;
    rchk(`SRG_OFS_CTRL, 32'h0);
    @(posedge clk);
    cmd_on <= 0;
    run_mode <= 1;
    $display("test modes done");
    final_report;
  end
  // tests need about 350 clocks; 10000 clocks is ample
  initial
  begin
    #40000;
    fails++;
    $display("watchdog expired");
    final_report;
  end
endmodule // srg_scan_ramp_tb_top
